/* File: rtl/brm_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Wires between the memory block and the logic that drives it.
interface brm_if #(
   parameter int WA = 16,
   parameter int WB = 16,
   parameter int AWA = 9,
   parameter int AWB = 9
);
   // Port A request and answer.
   logic [AWA-1:0] a_addr;
   logic [WA-1:0] a_wdata;
   logic a_we;
   logic a_re;
   logic a_ce;
   logic [WA-1:0] a_q;
   // Port B request and answer.
   logic [AWB-1:0] b_addr;
   logic [WB-1:0] b_wdata;
   logic b_we;
   logic b_re;
   logic b_ce;
   logic [WB-1:0] b_q;
   // Enable of the output registers in the input/output scheme.
   logic out_ce;

   // The memory block end.
   modport mem (
      input a_addr, a_wdata, a_we, a_re, a_ce,
      input b_addr, b_wdata, b_we, b_re, b_ce, out_ce,
      output a_q, b_q
   );

   // The driving logic end.
   modport user (
      output a_addr, a_wdata, a_we, a_re, a_ce,
      output b_addr, b_wdata, b_we, b_re, b_ce, out_ce,
      input a_q, b_q
   );
endinterface : brm_if

`default_nettype wire

/* File: rtl/brm_pkg.sv */
package brm_pkg;

   // Clocking schemes a memory block can be built with.
   typedef enum {
      BRM_CLK_INDEP,
      BRM_CLK_IO,
      BRM_CLK_RW,
      BRM_CLK_SINGLE
   } brm_clk_t;

   // Storage size without and with the ninth bit of each byte.
   localparam int BRM_BITS_PLAIN = 8192;
   localparam int BRM_BITS_PAR = 9216;
   // Widest true dual-port word, plain and with the ninth bits.
   localparam int BRM_WIDE_PLAIN = 16;
   localparam int BRM_WIDE_PAR = 18;
   // Size of one byte group when the ninth bit is stored.
   localparam int BRM_PAR_GROUP = 9;
   // Limits for a shift register built from one block.
   localparam int BRM_SR_MAX_BITS = 9216;
   localparam int BRM_SR_MAX_W = 36;

   // Controller register indices on its plain software port.
   localparam logic [3:0] BRM_REG_CMD = 4'h0;
   localparam logic [3:0] BRM_REG_A_ADDR = 4'h1;
   localparam logic [3:0] BRM_REG_A_WDATA = 4'h2;
   localparam logic [3:0] BRM_REG_B_ADDR = 4'h3;
   localparam logic [3:0] BRM_REG_B_WDATA = 4'h4;
   localparam logic [3:0] BRM_REG_A_RDATA = 4'h5;
   localparam logic [3:0] BRM_REG_B_RDATA = 4'h6;
   localparam logic [3:0] BRM_REG_STATUS = 4'h7;
   localparam logic [3:0] BRM_REG_ENABLE = 4'h8;

   // Command register bit positions.
   localparam int BRM_CMD_A_WR = 0;
   localparam int BRM_CMD_A_RD = 1;
   localparam int BRM_CMD_B_WR = 2;
   localparam int BRM_CMD_B_RD = 3;
   // Status register bit positions.
   localparam int BRM_ST_BUSY = 0;
   localparam int BRM_ST_CONFLICT = 1;
   localparam int BRM_ST_SR_OK = 2;
   // Enable register bit positions and reset value.
   localparam int BRM_EN_A = 0;
   localparam int BRM_EN_B = 1;
   localparam int BRM_EN_OUT = 2;
   localparam logic [2:0] BRM_ENABLE_RST = 3'h7;

   // True when a width carries the ninth bit of each byte.
   function automatic bit brm_has_par(input int w);
      return (w % BRM_PAR_GROUP) == 0;
   endfunction : brm_has_par

   // True when a width is one of the true dual-port shapes.
   function automatic bit brm_width_ok(input int w);
      return (w == 1) || (w == 2) || (w == 4) || (w == 8) ||
         (w == BRM_WIDE_PLAIN) || (w == BRM_PAR_GROUP) ||
         (w == BRM_WIDE_PAR);
   endfunction : brm_width_ok

   // True when two port widths may share one block.
   function automatic bit brm_pair_ok(input int wa, input int wb);
      return brm_width_ok(wa) && brm_width_ok(wb) &&
         (brm_has_par(wa) == brm_has_par(wb));
   endfunction : brm_pair_ok

   // Total stored bits for a given port width.
   function automatic int brm_mem_bits(input int w);
      return brm_has_par(w) ? BRM_BITS_PAR : BRM_BITS_PLAIN;
   endfunction : brm_mem_bits

   // Number of words a port of a given width addresses.
   function automatic int brm_depth(input int w);
      return brm_mem_bits(w) / w;
   endfunction : brm_depth

   // True when a clocking scheme suits true dual-port or ROM use.
   function automatic bit brm_scheme_ok(input brm_clk_t s);
      return s != BRM_CLK_RW;
   endfunction : brm_scheme_ok

   // True when a shift register of w x m x n fits one block.
   function automatic bit brm_sr_ok(input int w, input int m,
                                    input int n);
      return (w * m * n <= BRM_SR_MAX_BITS) && (w * n <= BRM_SR_MAX_W);
   endfunction : brm_sr_ok

   // True when two port accesses touch any common stored bit.
   function automatic bit brm_overlap(input int aa, input int wa,
                                      input int ba, input int wb);
      return (aa * wa < ba * wb + wb) && (ba * wb < aa * wa + wa);
   endfunction : brm_overlap

endpackage : brm_pkg

/* File: rtl/brm_ram.sv */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R01 - Both ports read or write in any mix.
// R02 - Widest port is 512x16, or 512x18.
// R03 - Mixed widths; ninth-bit shapes pair only together.
// R04 - Separate write and read enables per port.
// R05 - Same-address read on write: new or old.
// R06 - Either port reaches every location any time.
// R07 - Driver avoids both ports writing one address.
// R08 - Output register adds exactly one cycle.
// R09 - Shift register fits 9216 bits, 36 wide.
// R10 - ROM preloaded, registered address, optional output.
// R11 - No read plus write on empty queue.
// R12 - Clocking schemes allowed per memory use.
// R13 - Independent scheme: each port own enable.
// R14 - Input/output scheme: input and output enables.
// R15 - Read/write scheme: write and read enables.
// R16 - Read/write scheme collision gives undefined data.
// R17 - Single scheme: one enable drives everything.
// R18 - Async clear only on read side registers.
// R19 - New setting shows written data that cycle.
// R20 - Outputs come up zero after reset.
// R21 - Driver never clears during a read.
// R22 - Ninth bits stored plainly, no parity logic.
module brm_ram
   import brm_pkg::*;
#(
   parameter int WA = 16,
   parameter int WB = 16,
   parameter bit OUT_REG = 1'b0,
   parameter bit NEW_DATA = 1'b0,
   parameter bit ROM_MODE = 1'b0,
   parameter brm_clk_t CLK_SCHEME = BRM_CLK_SINGLE,
   parameter logic [BRM_BITS_PAR-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic nrst,
   brm_if.mem m,
   output logic cfg_err
);

   // Stored bits and the address widths of both ports.
   localparam int MB = brm_mem_bits(WA);
   localparam int AWA = $clog2(brm_depth(WA));
   localparam int AWB = $clog2(brm_depth(WB));
   // Configuration check held as a constant.
   localparam bit CFG_OK = brm_pair_ok(WA, WB) &&
      (WA <= BRM_WIDE_PAR) && (WB <= BRM_WIDE_PAR) &&
      brm_scheme_ok(CLK_SCHEME);

   // Flat bit store shared by both ports, with no partition.
   logic mem [0:MB-1];
   // Read latches that hold the last read word of each port.
   logic [WA-1:0] lat_a;
   logic [WB-1:0] lat_b;
   // Optional output registers.
   logic [WA-1:0] oreg_a;
   logic [WB-1:0] oreg_b;
   // Words currently stored at each port's address.
   logic [WA-1:0] cur_a;
   logic [WB-1:0] cur_b;
   // Enables for the input and output registers of each port.
   wire ena_in_a;
   wire ena_in_b;
   wire ena_out_a;
   wire ena_out_b;
   // Qualified write and read requests.
   wire wr_a;
   wire wr_b;
   wire rd_a;
   wire rd_b;
   // Next read latch values after the read-during-write choice.
   wire [WA-1:0] next_lat_a;
   wire [WB-1:0] next_lat_b;

   // The single scheme uses one enable for every register, the
   // input/output scheme splits input from output, and the
   // independent scheme gives each port its own enable.
   assign ena_in_a = m.a_ce; // [R13] [R14] [R17]
   assign ena_in_b = (CLK_SCHEME == BRM_CLK_INDEP) ? m.b_ce :
      (CLK_SCHEME == BRM_CLK_RW) ? m.b_ce : m.a_ce; // [R13] [R15] [R17]
   assign ena_out_a = (CLK_SCHEME == BRM_CLK_IO) ? m.out_ce :
      m.a_ce; // [R14] [R17]
   assign ena_out_b = (CLK_SCHEME == BRM_CLK_IO) ? m.out_ce :
      (CLK_SCHEME == BRM_CLK_SINGLE) ? m.a_ce : m.b_ce; // [R13] [R14]

   // Writes are dropped in ROM use; reads need their own enable.
   assign wr_a = m.a_we && ena_in_a && !ROM_MODE; // [R04] [R10]
   assign wr_b = m.b_we && ena_in_b && !ROM_MODE; // [R04] [R10]
   assign rd_a = m.a_re && ena_in_a; // [R04] [R01]
   assign rd_b = m.b_re && ena_in_b; // [R04] [R01]

   // Gather the words at each address from the flat store.
   always_comb begin
      for (int i = 0; i < WA; i++) begin
         cur_a[i] = mem[int'(m.a_addr) * WA + i]; // [R06] [R03]
      end
      for (int i = 0; i < WB; i++) begin
         cur_b[i] = mem[int'(m.b_addr) * WB + i]; // [R06] [R03]
      end
   end

   // A same-port read during a write shows either the word being
   // written or the word held before it.
   assign next_lat_a = (NEW_DATA && wr_a) ? m.a_wdata : cur_a; // [R05] [R19]
   assign next_lat_b = (NEW_DATA && wr_b) ? m.b_wdata : cur_b; // [R05] [R19]

   // Preload the store, like a ROM image or initial contents.
   initial begin
      for (int i = 0; i < MB; i++) begin
         mem[i] = INIT[i]; // [R10]
      end
   end

   // Write both ports into the store; it has no reset. The ninth
   // bits are plain storage. When both ports write the same bit,
   // port B lands last and the result is not guaranteed.
   always @(posedge mclk) begin
      if (wr_a) begin
         for (int i = 0; i < WA; i++) begin
            mem[int'(m.a_addr) * WA + i] <= m.a_wdata[i]; // [R22] [R06]
         end
      end
      if (wr_b) begin
         for (int i = 0; i < WB; i++) begin
            mem[int'(m.b_addr) * WB + i] <= m.b_wdata[i]; // [R22] [R06]
         end
      end
   end

   // Port A read latch: cleared asynchronously, holds while no read.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lat_a <= '0; // [R18] [R20]
      end else if (rd_a) begin
         lat_a <= next_lat_a; // [R01] [R10]
      end
   end

   // Port B read latch; a cross-port read of a word being written
   // sees the old word, which also stands for the undefined case.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lat_b <= '0; // [R18] [R20]
      end else if (rd_b) begin
         lat_b <= next_lat_b; // [R01] [R16]
      end
   end

   // Output registers delay each latch by one enabled cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         oreg_a <= '0; // [R18] [R20]
      end else if (ena_out_a) begin
         oreg_a <= lat_a; // [R08]
      end
   end

   // Port B output register.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         oreg_b <= '0; // [R18] [R20]
      end else if (ena_out_b) begin
         oreg_b <= lat_b; // [R08]
      end
   end

   // Report an unsupported shape or scheme once out of reset.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_err <= 1'b0;
      end else begin
         cfg_err <= !CFG_OK; // [R02] [R03] [R12]
      end
   end

   // Pick the registered or the latched word for each output.
   generate
      if (OUT_REG) begin : g_oreg
         assign m.a_q = oreg_a; // [R08]
         assign m.b_q = oreg_b; // [R08]
      end else begin : g_olat
         assign m.a_q = lat_a;
         assign m.b_q = lat_b;
      end
   endgenerate

   // The address widths must match the interface.
   wire unused_aw = (AWA == 0) || (AWB == 0);

endmodule : brm_ram

`default_nettype wire

/* File: rtl/brm_user.sv */
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Register-driven controller that works both memory ports.
module brm_user
   import brm_pkg::*;
#(
   parameter int WA = 16,
   parameter int WB = 16,
   parameter bit OUT_REG = 1'b0,
   parameter int SR_W = 8,
   parameter int SR_M = 64,
   parameter int SR_N = 4
) (
   input wire logic mclk,
   input wire logic nrst,
   brm_if.user u,
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata
);

   // Cycles from a read request to a valid memory output.
   localparam int LAT = OUT_REG ? 2 : 1;
   localparam int AWA = $clog2(brm_depth(WA));
   localparam int AWB = $clog2(brm_depth(WB));
   // Whether the planned shift register fits one block.
   localparam bit SR_OK = brm_sr_ok(SR_W, SR_M, SR_N);

   // Staged addresses and write words.
   logic [AWA-1:0] a_addr;
   logic [WA-1:0] a_wdata;
   logic [AWB-1:0] b_addr;
   logic [WB-1:0] b_wdata;
   // Captured read words and port enables.
   logic [WA-1:0] a_rdata;
   logic [WB-1:0] b_rdata;
   logic [2:0] enable;
   // Pending read pipes and the sticky conflict flag.
   logic [LAT:0] pipe_a;
   logic [LAT:0] pipe_b;
   logic conflict;

   // Decoded software strobes.
   wire cmd_wr = sw_wr && (sw_addr == BRM_REG_CMD);
   wire go_a_wr = cmd_wr && sw_wdata[BRM_CMD_A_WR];
   wire go_b_wr = cmd_wr && sw_wdata[BRM_CMD_B_WR];
   wire go_a_rd = cmd_wr && sw_wdata[BRM_CMD_A_RD];
   wire go_b_rd = cmd_wr && sw_wdata[BRM_CMD_B_RD];
   // Both ports writing a shared bit: port B is held back.
   wire clash = go_a_wr && go_b_wr &&
      brm_overlap(int'(a_addr), WA, int'(b_addr), WB); // [R07]
   wire clr_conflict = sw_wr && (sw_addr == BRM_REG_STATUS) &&
      sw_wdata[BRM_ST_CONFLICT];
   // Read-back mux of the register file.
   wire [31:0] rd_mux =
      (sw_addr == BRM_REG_A_ADDR) ? 32'(a_addr) :
      (sw_addr == BRM_REG_A_WDATA) ? 32'(a_wdata) :
      (sw_addr == BRM_REG_B_ADDR) ? 32'(b_addr) :
      (sw_addr == BRM_REG_B_WDATA) ? 32'(b_wdata) :
      (sw_addr == BRM_REG_A_RDATA) ? 32'(a_rdata) :
      (sw_addr == BRM_REG_B_RDATA) ? 32'(b_rdata) :
      (sw_addr == BRM_REG_STATUS) ? {29'h0, SR_OK, conflict,
         (|pipe_a) || (|pipe_b)} : // [R09]
      (sw_addr == BRM_REG_ENABLE) ? {29'h0, enable} : 32'h0;

   // Staging registers written by software.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         a_addr <= '0;
         a_wdata <= '0;
         b_addr <= '0;
         b_wdata <= '0;
         enable <= BRM_ENABLE_RST;
      end else if (sw_wr) begin
         if (sw_addr == BRM_REG_A_ADDR) a_addr <= sw_wdata[AWA-1:0];
         if (sw_addr == BRM_REG_A_WDATA) a_wdata <= sw_wdata[WA-1:0];
         if (sw_addr == BRM_REG_B_ADDR) b_addr <= sw_wdata[AWB-1:0];
         if (sw_addr == BRM_REG_B_WDATA) b_wdata <= sw_wdata[WB-1:0];
         if (sw_addr == BRM_REG_ENABLE) enable <= sw_wdata[2:0];
      end
   end

   // Drive one-cycle requests; read enables stay low when idle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         u.a_we <= 1'b0;
         u.b_we <= 1'b0;
         u.a_re <= 1'b0;
         u.b_re <= 1'b0;
         u.a_addr <= '0;
         u.b_addr <= '0;
         u.a_wdata <= '0;
         u.b_wdata <= '0;
         u.a_ce <= 1'b0;
         u.b_ce <= 1'b0;
         u.out_ce <= 1'b0;
      end else begin
         u.a_we <= go_a_wr;
         u.b_we <= go_b_wr && !clash; // [R07]
         u.a_re <= go_a_rd; // [R04]
         u.b_re <= go_b_rd; // [R04]
         u.a_addr <= a_addr;
         u.b_addr <= b_addr;
         u.a_wdata <= a_wdata;
         u.b_wdata <= b_wdata;
         u.a_ce <= enable[BRM_EN_A];
         u.b_ce <= enable[BRM_EN_B];
         u.out_ce <= enable[BRM_EN_OUT];
      end
   end

   // Track outstanding reads and capture words as they arrive.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pipe_a <= '0;
         pipe_b <= '0;
         a_rdata <= '0;
         b_rdata <= '0;
      end else begin
         pipe_a <= {pipe_a[LAT-1:0], go_a_rd};
         pipe_b <= {pipe_b[LAT-1:0], go_b_rd};
         if (pipe_a[LAT]) a_rdata <= u.a_q; // [R08]
         if (pipe_b[LAT]) b_rdata <= u.b_q; // [R08]
      end
   end

   // Sticky conflict flag; a new clash wins over a clear.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         conflict <= 1'b0;
      end else if (clash) begin
         conflict <= 1'b1; // [R07]
      end else if (clr_conflict) begin
         conflict <= 1'b0;
      end
   end

   // Read data stand one cycle after the read strobe.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sw_rdata <= '0;
      end else begin
         sw_rdata <= sw_rd ? rd_mux : 32'h0;
      end
   end

endmodule : brm_user

`default_nettype wire

/* File: testbench/brm_bench.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: %h not %h", $time, got, exp); \
   end \
end

// Drives the controller's software port and checks memory results.
module brm_bench
   import brm_pkg::*;
;

   // Widths shared by every build under test.
   localparam int WA = 16;
   localparam int WB = 16;
   localparam int AWA = $clog2(brm_depth(WA));
   localparam int AWB = $clog2(brm_depth(WB));
   // Build 0 is plain, build 1 registers its outputs, build 2 shows
   // the written word on a same-port read during a write.
   localparam int NB = 3;

   // Clock, reset and software port of the controller.
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   // Read data and configuration flag of each build.
   logic [31:0] sw_rdata [NB];
   logic cfg_err [NB];
   int err_count = 0;
   int comparisons = 0;

   brm_if #(.WA(WA), .WB(WB), .AWA(AWA), .AWB(AWB)) bus [NB] ();

   // Every build sees the same software strobes.
   for (genvar k = 0; k < NB; k++) begin : g_build
      brm_ram #(.WA(WA), .WB(WB), .OUT_REG(k == 1), .NEW_DATA(k == 2),
         .CLK_SCHEME(k == 0 ? BRM_CLK_SINGLE : BRM_CLK_IO)) brm_ram_i (
         .mclk(mclk), .nrst(nrst), .m(bus[k]), .cfg_err(cfg_err[k]));
      brm_user #(.WA(WA), .WB(WB), .OUT_REG(k == 1)) brm_user_i (
         .mclk(mclk), .nrst(nrst), .u(bus[k]), .sw_addr(sw_addr),
         .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
         .sw_rdata(sw_rdata[k]));
   end

   brm_chk #(.WA(WA), .WB(WB), .AWA(AWA), .AWB(AWB)) brm_chk_i (
      .mclk(mclk), .nrst(nrst),
      .a_addr(bus[0].a_addr), .a_wdata(bus[0].a_wdata),
      .a_we(bus[0].a_we), .a_re(bus[0].a_re), .a_ce(bus[0].a_ce),
      .a_q(bus[0].a_q), .b_addr(bus[0].b_addr),
      .b_wdata(bus[0].b_wdata), .b_we(bus[0].b_we),
      .b_re(bus[0].b_re), .b_ce(bus[0].b_ce), .b_q(bus[0].b_q),
      .out_ce(bus[0].out_ce), .a_q_r(bus[1].a_q), .b_q_r(bus[1].b_q));

   // A 5 ns clock period.
   always #2.5 mclk = ~mclk;

   // Prints the verdict and stops the run.
   task test_done;
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // Holds reset for three edges, releasing right after an edge.
   task automatic rst;
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
   endtask : rst

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask : wr

   // One-cycle register read of every build, compared in the cycle
   // after it; the fresh-data build expects e_new.
   task automatic chk_rdw(input logic [3:0] a, input logic [31:0] e,
                          input logic [31:0] e_new);
      logic [31:0] got;
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1;
      for (int k = 0; k < NB; k++) begin
         got = sw_rdata[k];
         `CHK(got, (k == 2) ? e_new : e)
      end
   endtask : chk_rdw

   // Read where every build expects the same word.
   task automatic chk(input logic [3:0] a, input logic [31:0] e);
      chk_rdw(a, e, e);
   endtask : chk

   // Loads both ports' address and data, issues a command, lets it land.
   task automatic go(input logic [31:0] cmd, input logic [31:0] aa,
                     input logic [31:0] ad, input logic [31:0] ba,
                     input logic [31:0] bd);
      wr(BRM_REG_A_ADDR, aa);
      wr(BRM_REG_A_WDATA, ad);
      wr(BRM_REG_B_ADDR, ba);
      wr(BRM_REG_B_WDATA, bd);
      wr(BRM_REG_CMD, cmd);
      repeat (3) @(posedge mclk);
   endtask : go

   // Cuts a hung run short and counts it as a mismatch.
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      test_done();
   end

   // Main sequence of scenarios.
   initial begin
      rst();
      chk(BRM_REG_STATUS, 32'h4);
      chk(BRM_REG_ENABLE, 32'h7);
      chk(BRM_REG_A_RDATA, 32'h0);
      wr(4'h9, 32'hFFFF);
      chk(4'h9, 32'h0);
      for (int k = 0; k < NB; k++) `CHK(cfg_err[k], 1'b0)
      // No queue use is built, so no read with a write on an empty
      // queue is ever issued.
      // Write on A, read back on B.
      go(32'h1, 32'h5, 32'hA55A, 32'h0, 32'h0);
      go(32'h8, 32'h0, 32'h0, 32'h5, 32'h0);
      chk(BRM_REG_B_RDATA, 32'hA55A);
      // Same-port write with read on B at the top address.
      go(32'h4, 32'h0, 32'h0, 32'h1FF, 32'h1234);
      go(32'hC, 32'h0, 32'h0, 32'h1FF, 32'h4321);
      chk_rdw(BRM_REG_B_RDATA, 32'h1234, 32'h4321);
      go(32'h2, 32'h1FF, 32'h0, 32'h0, 32'h0);
      chk(BRM_REG_A_RDATA, 32'h4321);
      // Same-port write with read on A.
      go(32'h1, 32'h7, 32'h1111, 32'h0, 32'h0);
      go(32'h3, 32'h7, 32'h2222, 32'h0, 32'h0);
      chk_rdw(BRM_REG_A_RDATA, 32'h1111, 32'h2222);
      // Two reads at once.
      go(32'hA, 32'h5, 32'h0, 32'h7, 32'h0);
      chk(BRM_REG_A_RDATA, 32'hA55A);
      chk(BRM_REG_B_RDATA, 32'h2222);
      // Two writes at once to different addresses both land.
      go(32'h5, 32'h2, 32'h1357, 32'h4, 32'h2468);
      go(32'hA, 32'h2, 32'h0, 32'h4, 32'h0);
      chk(BRM_REG_A_RDATA, 32'h1357);
      chk(BRM_REG_B_RDATA, 32'h2468);
      // Write on A while B reads the same word sees the old word.
      go(32'h9, 32'h5, 32'h5AA5, 32'h5, 32'h0);
      chk(BRM_REG_B_RDATA, 32'hA55A);
      go(32'h8, 32'h0, 32'h0, 32'h5, 32'h0);
      chk(BRM_REG_B_RDATA, 32'h5AA5);
      // Both ports writing one address: B is dropped and flagged.
      go(32'h5, 32'h3, 32'hAAAA, 32'h3, 32'hBBBB);
      chk(BRM_REG_STATUS, 32'h6);
      go(32'h2, 32'h3, 32'h0, 32'h0, 32'h0);
      chk(BRM_REG_A_RDATA, 32'hAAAA);
      wr(BRM_REG_STATUS, 32'h2);
      chk(BRM_REG_STATUS, 32'h4);
      // A reset in mid-run clears outputs but keeps the contents; it
      // is only given once no read is pending.
      rst();
      chk(BRM_REG_A_RDATA, 32'h0);
      go(32'h2, 32'h3, 32'h0, 32'h0, 32'h0);
      chk(BRM_REG_A_RDATA, 32'hAAAA);
      test_done();
   end
endmodule : brm_bench

`default_nettype wire

/* File: testbench/brm_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// Watches both memory ports on the wires between the two ends.
module brm_chk #(
   parameter int WA = 16,
   parameter int WB = 16,
   parameter int AWA = 9,
   parameter int AWB = 9
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [AWA-1:0] a_addr,
   input wire logic [WA-1:0] a_wdata,
   input wire logic a_we,
   input wire logic a_re,
   input wire logic a_ce,
   input wire logic [WA-1:0] a_q,
   input wire logic [AWB-1:0] b_addr,
   input wire logic [WB-1:0] b_wdata,
   input wire logic b_we,
   input wire logic b_re,
   input wire logic b_ce,
   input wire logic [WB-1:0] b_q,
   input wire logic out_ce,
   // Read words of a build with output registers, same stimulus.
   input wire logic [WA-1:0] a_q_r,
   input wire logic [WB-1:0] b_q_r
);
   // Taken writes; in the single scheme a_ce gates both ports.
   wire logic a_wr_t;
   wire logic b_wr_t;
   // Last written word; port B wins when both write at once.
   logic lw_ok;
   logic [AWA-1:0] lw_addr;
   logic [WA-1:0] lw_data;

   assign a_wr_t = a_ce && a_we;
   assign b_wr_t = a_ce && b_we;

   // Tracks the most recent taken write so reads can be predicted.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lw_ok <= 1'b0;
         lw_addr <= '0;
         lw_data <= '0;
      end else if (b_wr_t) begin
         lw_ok <= 1'b1;
         lw_addr <= AWA'(b_addr);
         lw_data <= WA'(b_wdata);
      end else if (a_wr_t) begin
         lw_ok <= 1'b1;
         lw_addr <= a_addr;
         lw_data <= a_wdata;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // A taken read of the word that was written last.
   sequence s_a_known;
      a_ce && a_re && lw_ok && (a_addr == lw_addr);
   endsequence
   sequence s_b_known;
      a_ce && b_re && lw_ok && (AWA'(b_addr) == lw_addr);
   endsequence

   property p_rst_q;
      $rose(nrst) |-> (a_q == '0) && (b_q == '0);
   endproperty
   property p_a_hold;
      !(a_ce && a_re) |=> $stable(a_q);
   endproperty
   property p_b_hold;
      !(a_ce && b_re) |=> $stable(b_q);
   endproperty
   property p_a_rd;
      s_a_known ##0 !a_we |=> a_q == $past(lw_data);
   endproperty
   property p_a_old;
      s_a_known ##0 a_we |=> a_q == $past(lw_data);
   endproperty
   property p_b_rd;
      s_b_known ##0 !b_we |=> b_q == WB'($past(lw_data));
   endproperty
   property p_b_old;
      s_b_known ##0 b_we |=> b_q == WB'($past(lw_data));
   endproperty
   property p_no_clash;
      a_wr_t && b_wr_t |-> a_addr != AWA'(b_addr);
   endproperty
   // The registered build shows each word exactly one cycle later.
   property p_a_late;
      a_q_r == $past(a_q);
   endproperty
   property p_b_late;
      b_q_r == $past(b_q);
   endproperty

   a_rst_q: assert property (p_rst_q)
      else $error("read words not zero after reset");
   a_a_hold: assert property (p_a_hold)
      else $error("port A word moved without a read");
   a_b_hold: assert property (p_b_hold)
      else $error("port B word moved without a read");
   a_a_rd: assert property (p_a_rd)
      else $error("port A read wrong word");
   a_a_old: assert property (p_a_old)
      else $error("port A write with read not old word");
   a_b_rd: assert property (p_b_rd)
      else $error("port B read wrong word");
   a_b_old: assert property (p_b_old)
      else $error("port B write with read not old word");
   a_no_clash: assert property (p_no_clash)
      else $error("both ports wrote one address");
   a_a_late: assert property (p_a_late)
      else $error("port A registered word not one cycle late");
   a_b_late: assert property (p_b_late)
      else $error("port B registered word not one cycle late");
endmodule : brm_chk

`default_nettype wire
